/* hw/dtd_pkg.sv */
// Purpose: shared constants and types for the dma channel trigger/descriptor block
// Assumes: 32-bit words, word-wide transfers
// Notes:   transfer_config field layout is fixed by the struct below
package dtd_pkg;
  localparam int unsigned DATA_W     = 32;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned TRIGGERED_FLAG_SRC_N = 20;
  localparam int unsigned TRIGGERED_FLAG_SEL_W = 5;
  localparam int unsigned CNT_W      = 10;
  // trigger source index map
  localparam int unsigned TSRC_ADC   = 0;
  localparam int unsigned TSRC_STIM  = 2;
  localparam int unsigned TSRC_TMR   = 4;
  localparam int unsigned TSRC_PIN   = 12;
  localparam int unsigned TSRC_CHAIN = 16;
  // descriptor word offsets in bytes
  localparam logic [31:0] DESC_OFS_CFG  = 32'h0;
  localparam logic [31:0] DESC_OFS_SRC  = 32'h4;
  localparam logic [31:0] DESC_OFS_DST  = 32'h8;
  localparam logic [31:0] DESC_OFS_LINK = 32'hc;
  localparam logic [31:0] WORD_BYTES    = 32'h4;
  localparam logic [1:0]  DESC_LAST_IDX = 2'h3;

  typedef struct packed {
    logic [5:0]  rsvd_hi;
    logic [9:0]  transfer_count;        // elements minus one
    logic [1:0]  destination_increment; // 0 none, 1 x1, 2 x2, 3 x4 words
    logic [1:0]  source_increment;
    logic [8:0]  rsvd_mid;
    logic        immediate_start_bit;
    logic        reload;
    logic        clear_trigger_on_exhaust; // bit 0
  } dtd_xfer_cfg_s;

  typedef struct packed {
    logic hw_trigger_enable;
    logic trigger_polarity;      // 1 high / rising
    logic trigger_edge_or_level; // 0 edge, 1 level
    logic trigger_burst_select;  // 1 whole descriptor per trigger
    logic request_pacing_enable;
  } dtd_chan_cfg_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dtd_bus_req_s;

  localparam dtd_xfer_cfg_s XFER_CFG_RST = '0;
  localparam dtd_bus_req_s  BUS_RST      = '0;

  typedef enum logic [1:0] {
    ST_STOP  = 2'b00,
    ST_FETCH = 2'b01,
    ST_XFER  = 2'b10,
    ST_END   = 2'b11
  } dtd_state_e;

  typedef enum logic [1:0] {
    MON_NONE   = 2'b00,
    MON_MASTER = 2'b01,
    MON_SLAVE  = 2'b10
  } dtd_mon_e;
endpackage

/* hw/dtd_fifo.sv */
// Purpose: small synchronous fifo between bus reads and bus writes
// Assumes: single clock, push and pop may coincide
// Notes:   storage in flip-flops addressed by index
`timescale 1ns/1ps
`default_nettype none
module dtd_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_i,     // system clock
  input  wire logic             arst_n_i,  // async reset, low
  input  wire logic             ce_i,      // clock enable
  input  wire logic             in_valid_i, // push
  output logic                  in_ready_o, // not full
  input  wire logic [WIDTH-1:0] in_data_i, // push data
  output logic                  out_valid_o, // not empty
  input  wire logic             out_ready_i, // pop
  output logic [WIDTH-1:0]      out_data_o // head word
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      cnt_reg;
  logic             push;
  logic             pop;

  assign in_ready_o  = (cnt_reg != (AW+1)'(DEPTH)); // depth needs the extra level bit
  assign out_valid_o = (cnt_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = ce_i & in_valid_i & in_ready_o;
  assign pop         = ce_i & out_ready_i & out_valid_o;

  // storage, no reset needed for the data words
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    cnt_reg <= (AW+1)'(DEPTH)) else $error("fifo level above depth");
endmodule
`default_nettype wire

/* hw/dtd_triggered_flag_in.sv */
// Purpose: trigger source select with polarity and edge/level qualification
// Assumes: sources synchronous to clk_i
// Notes:   a selection beyond the last source never fires
`timescale 1ns/1ps
`default_nettype none
module dtd_triggered_flag_in
  import dtd_pkg::*;
(
  input  wire logic                  clk_i,      // system clock
  input  wire logic                  arst_n_i,   // async reset, low
  input  wire logic                  ce_i,       // clock enable
  input  wire logic [TRIGGERED_FLAG_SRC_N-1:0] src_i,      // all trigger sources
  input  wire logic [TRIGGERED_FLAG_SEL_W-1:0] sel_i,      // source index
  input  wire logic                  polarity_i, // 1 active high
  input  wire logic                  level_i,    // 1 level, 0 edge
  output logic                       hit_o       // qualified trigger
);
  logic active;
  logic prev_reg;

  // per-channel selection mux, independent of the request line
  assign active = (sel_i < TRIGGERED_FLAG_SEL_W'(TRIGGERED_FLAG_SRC_N)) &&
                  (src_i[sel_i] == polarity_i); // see R01 see R05

  // previous level for edge detection; frozen with ce_i
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      prev_reg <= 1'b1; // no false edge if a source idles at its active level
    end else if (ce_i) begin
      prev_reg <= active;
    end
  end

  assign hit_o = level_i ? active : (active & ~prev_reg); // see R10
endmodule
`default_nettype wire

/* hw/dtd_channel.sv */
// Purpose: one dma channel: triggering, pacing, descriptor fetch and reload
// Assumes: single-outstanding bus master, word transfers, sources synchronous
// Notes:   reads fill the fifo, writes drain it; one bus op at a time
`timescale 1ns/1ps
`default_nettype none
// Contract
// R01 - one request line and one trigger input chosen by a select mux
// R02 - monitor dma with master dma off uses the master channel
// R03 - master dma on, slave off: monitor uses the slave channel
// R04 - master and slave dma both on: monitor gets no dma
// R05 - twenty trigger sources, independent of the request input
// R06 - sources: 0-1 converter, 2-3 state timer, 4-11 timers, 12-15 pins, 16-19 chain
// R07 - channel drives a trigger output usable by another channel
// R08 - no transfer before the channel is triggered
// R09 - writing the trigger-set bit marks the channel triggered
// R10 - hardware trigger follows enable, polarity, edge/level and burst settings
// R11 - immediate start bit triggers the channel at once
// R12 - pacing on: one transfer per request; otherwise full speed
// R13 - clear-trigger bit clears triggered flag when descriptor is exhausted
// R14 - descriptor words: reserved, source end, destination end, link
// R15 - start address is end minus count times increment
// R16 - link followed only for linked transfers; end marks last element
// R17 - on exhaustion with reload, fetch at link; word zero gives config
// R18 - reload repeats while each new config selects reload
// R19 - software aligns linked descriptors to sixteen bytes
// R20 - converter reaches the channel only through trigger sources
// R21 - exhausted without reload: stop, ignore requests until reconfigured
// R22 - fetch the four-word descriptor before its transfers start
module dtd_channel
  import dtd_pkg::*;
(
  input  wire logic                 clk_i,            // system clock, 10 MHz
  input  wire logic                 arst_n_i,         // async reset, low
  input  wire logic                 ce_i,             // clock enable
  input  wire dtd_pkg::dtd_chan_cfg_s chan_cfg_i,     // channel configuration
  input  wire dtd_pkg::dtd_xfer_cfg_s transfer_config_i, // software transfer config
  input  wire logic                 cfg_valid_i,      // pulse: start from stop
  input  wire logic [31:0]          desc_base_i,      // channel descriptor address
  input  wire logic                 trigger_set_register_i, // pulse: software trigger
  input  wire logic [4:0]           trigger_input_select_i, // trigger source index
  input  wire logic [1:0]           adc_seq_i,        // converter sequence irqs
  input  wire logic [1:0]           state_timer_req_i, // state timer requests
  input  wire logic [7:0]           timer_match_i,    // timer match requests
  input  wire logic [3:0]           pin_int_i,        // pin interrupts
  input  wire logic [3:0]           chain_triggered_flag_i,     // dma output triggers 0-3
  input  wire logic                 periph_req_i,     // peripheral request
  input  wire logic                 mst_dma_en_i,     // two-wire master dma on
  input  wire logic                 slv_dma_en_i,     // two-wire slave dma on
  input  wire logic                 mon_dma_en_i,     // two-wire monitor dma on
  output var dtd_pkg::dtd_bus_req_s bus_o,            // bus request, held to ack
  input  wire logic                 bus_ack_i,        // bus op done
  input  wire logic [31:0]          bus_rdata_i,      // read data with ack
  output logic                      triggered_o,      // triggered flag
  output logic                      active_o,         // channel not stopped
  output logic                      triggered_flag_out_o,       // exhaustion pulse
  output var dtd_pkg::dtd_mon_e     mon_route_o       // monitor channel route
);
  import dtd_pkg::*;

  dtd_state_e       state_reg;
  dtd_xfer_cfg_s    cfg_reg;
  dtd_bus_req_s     bus_reg;
  logic             triggered_reg;
  logic             active_reg;
  logic             triggered_flag_out_reg;
  dtd_mon_e         mon_reg;
  logic             req_pend_reg;
  logic             reload_fetch_reg;
  logic [1:0]       fidx_reg;
  logic [31:0]      fbase_reg;
  logic [31:0]      src_end_reg;
  logic [31:0]      dst_end_reg;
  logic [31:0]      link_reg;
  logic [31:0]      src_cur_reg;
  logic [31:0]      dst_cur_reg;
  logic [CNT_W:0]   rd_left_reg;
  logic [CNT_W:0]   wr_left_reg;
  logic [TRIGGERED_FLAG_SRC_N-1:0] triggered_flag_src;
  logic             hw_hit;
  logic             set_ev;
  logic             clr_ev;
  logic             rd_ok;
  logic             issue_rd;
  logic             issue_wr;
  logic             fetch_done;
  logic             f_in_ready;
  logic             f_out_valid;
  logic [31:0]      f_out_data;

  // byte step of one element for an increment code
  function automatic logic [31:0] inc_step(input logic [1:0] code);
    case (code)
      2'h0:    inc_step = 32'h0;
      2'h1:    inc_step = WORD_BYTES;
      2'h2:    inc_step = WORD_BYTES << 1;
      default: inc_step = WORD_BYTES << 2;
    endcase
  endfunction

  // span from first to last element: count times step
  function automatic logic [31:0] span(input logic [CNT_W-1:0] cnt, input logic [1:0] code);
    span = 32'(cnt) * inc_step(code);
  endfunction

  // source order fixes the index map; converter appears only here, no request
  assign triggered_flag_src = {chain_triggered_flag_i, pin_int_i, timer_match_i,
                     state_timer_req_i, adc_seq_i}; // see R06 see R20

  dtd_triggered_flag_in u_triggered_flag (
    .clk_i      (clk_i),
    .arst_n_i   (arst_n_i),
    .ce_i       (ce_i),
    .src_i      (triggered_flag_src),
    .sel_i      (trigger_input_select_i),
    .polarity_i (chan_cfg_i.trigger_polarity),
    .level_i    (chan_cfg_i.trigger_edge_or_level),
    .hit_o      (hw_hit)
  );

  // read permitted: triggered, room in fifo, and a request if paced
  assign rd_ok    = triggered_reg && (rd_left_reg != '0) && f_in_ready &&
                    (!chan_cfg_i.request_pacing_enable || req_pend_reg); // see R08 see R12
  assign issue_rd = ce_i && (state_reg == ST_XFER) && !bus_reg.req && rd_ok;
  assign issue_wr = ce_i && (state_reg == ST_XFER) && !bus_reg.req && !rd_ok && f_out_valid;
  assign fetch_done = ce_i && (state_reg == ST_FETCH) && bus_reg.req && bus_ack_i &&
                      (fidx_reg == DESC_LAST_IDX);

  // triggers are ignored while stopped; the immediate bit triggers a channel as cfg_valid_i starts it
  always_comb begin
    set_ev = 1'b0;
    if (state_reg != ST_STOP) begin
      set_ev = trigger_set_register_i ||
               (chan_cfg_i.hw_trigger_enable && hw_hit); // see R09 see R10 see R21
    end
    if (state_reg == ST_STOP && cfg_valid_i && transfer_config_i.immediate_start_bit) begin
      set_ev = 1'b1; // see R11
    end
    if (state_reg == ST_FETCH && reload_fetch_reg && fidx_reg == 2'h0 &&
        bus_reg.req && bus_ack_i && bus_rdata_i[2]) begin
      set_ev = 1'b1; // reloaded config may carry the immediate bit
    end
  end

  // clear on exhaustion, or after each element when a trigger buys one element
  assign clr_ev = (state_reg == ST_END && cfg_reg.clear_trigger_on_exhaust) ||
                  (issue_rd && chan_cfg_i.hw_trigger_enable &&
                   !chan_cfg_i.trigger_burst_select); // see R13 see R10

  // triggered flag; a set in the clearing cycle wins so no trigger is lost
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      triggered_reg <= 1'b0;
    end else if (ce_i) begin
      if (set_ev) begin
        triggered_reg <= 1'b1;
      end else if (clr_ev) begin
        triggered_reg <= 1'b0;
      end
    end
  end

  // pending peripheral request, consumed by one read; request set wins
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      req_pend_reg <= 1'b0;
    end else if (ce_i) begin
      if (periph_req_i && state_reg != ST_STOP) begin
        req_pend_reg <= 1'b1;
      end else if (issue_rd || state_reg == ST_STOP) begin
        req_pend_reg <= 1'b0; // see R12
      end
    end
  end

  // channel sequencer
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg        <= ST_STOP;
      reload_fetch_reg <= 1'b0;
      fbase_reg        <= '0;
    end else if (ce_i) begin
      case (state_reg)
        ST_STOP: begin
          if (cfg_valid_i) begin
            state_reg        <= ST_FETCH; // see R22
            reload_fetch_reg <= 1'b0;
            fbase_reg        <= desc_base_i;
          end
        end
        ST_FETCH: begin
          if (fetch_done) begin
            state_reg <= ST_XFER;
          end
        end
        ST_XFER: begin
          if (wr_left_reg == '0 && !bus_reg.req) begin
            state_reg <= ST_END;
          end
        end
        default: begin
          if (cfg_reg.reload) begin
            state_reg        <= ST_FETCH; // see R16 see R17 see R18
            reload_fetch_reg <= 1'b1;
            fbase_reg        <= link_reg; // aligned by software, see R19
          end else begin
            state_reg <= ST_STOP; // see R21
          end
        end
      endcase
    end
  end

  // descriptor words land by index; reload takes config from word zero
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fidx_reg    <= '0;
      cfg_reg     <= XFER_CFG_RST;
      src_end_reg <= '0;
      dst_end_reg <= '0;
      link_reg    <= '0;
    end else if (ce_i) begin
      if (state_reg == ST_STOP && cfg_valid_i) begin
        cfg_reg  <= transfer_config_i;
        fidx_reg <= '0;
      end else if (state_reg == ST_END) begin
        fidx_reg <= '0;
      end else if (state_reg == ST_FETCH && bus_reg.req && bus_ack_i) begin
        fidx_reg <= fidx_reg + 2'h1;
        case (fidx_reg)
          2'h0: begin
            if (reload_fetch_reg) begin
              cfg_reg <= dtd_xfer_cfg_s'(bus_rdata_i); // see R17
            end
          end
          2'h1:    src_end_reg <= bus_rdata_i; // see R14
          2'h2:    dst_end_reg <= bus_rdata_i;
          default: link_reg    <= bus_rdata_i;
        endcase
      end
    end
  end

  // working addresses start below the end addresses; counts per element
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      src_cur_reg <= '0;
      dst_cur_reg <= '0;
      rd_left_reg <= '0;
      wr_left_reg <= '0;
    end else if (ce_i) begin
      if (fetch_done) begin
        src_cur_reg <= src_end_reg - span(cfg_reg.transfer_count,
                                          cfg_reg.source_increment); // see R15
        dst_cur_reg <= dst_end_reg - span(cfg_reg.transfer_count,
                                          cfg_reg.destination_increment);
        rd_left_reg <= (CNT_W+1)'(cfg_reg.transfer_count) + 1'b1;
        wr_left_reg <= (CNT_W+1)'(cfg_reg.transfer_count) + 1'b1;
      end
      if (issue_rd) begin
        src_cur_reg <= src_cur_reg + inc_step(cfg_reg.source_increment);
        rd_left_reg <= rd_left_reg - 1'b1;
      end
      if (issue_wr) begin
        dst_cur_reg <= dst_cur_reg + inc_step(cfg_reg.destination_increment);
        wr_left_reg <= wr_left_reg - 1'b1;
      end
    end
  end

  // bus master: one request held until ack
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bus_reg <= BUS_RST;
    end else if (ce_i) begin
      if (bus_reg.req) begin
        if (bus_ack_i) begin
          bus_reg.req <= 1'b0;
        end
      end else if (state_reg == ST_FETCH) begin
        bus_reg.req  <= 1'b1;
        bus_reg.we   <= 1'b0;
        bus_reg.addr <= fbase_reg + {28'h0, fidx_reg, 2'b00}; // see R22
      end else if (issue_rd) begin
        bus_reg.req  <= 1'b1;
        bus_reg.we   <= 1'b0;
        bus_reg.addr <= src_cur_reg;
      end else if (issue_wr) begin
        bus_reg.req   <= 1'b1;
        bus_reg.we    <= 1'b1;
        bus_reg.addr  <= dst_cur_reg;
        bus_reg.wdata <= f_out_data;
      end
    end
  end

  // reads park data here; a full fifo stalls further reads
  dtd_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .arst_n_i    (arst_n_i),
    .ce_i        (ce_i),
    .in_valid_i  (state_reg == ST_XFER && bus_reg.req && !bus_reg.we && bus_ack_i),
    .in_ready_o  (f_in_ready),
    .in_data_i   (bus_rdata_i),
    .out_valid_o (f_out_valid),
    .out_ready_i (issue_wr),
    .out_data_o  (f_out_data)
  );

  // status, chain trigger output and monitor routing, all registered
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      active_reg   <= 1'b0;
      triggered_flag_out_reg <= 1'b0;
      mon_reg      <= MON_NONE;
    end else if (ce_i) begin
      active_reg   <= (state_reg != ST_STOP) || cfg_valid_i;
      triggered_flag_out_reg <= (state_reg == ST_END); // see R07
      if (mon_dma_en_i && !mst_dma_en_i) begin
        mon_reg <= MON_MASTER; // see R02
      end else if (mon_dma_en_i && !slv_dma_en_i) begin
        mon_reg <= MON_SLAVE; // see R03
      end else begin
        mon_reg <= MON_NONE; // see R04
      end
    end
  end

  assign bus_o       = bus_reg;
  assign triggered_o = triggered_reg;
  assign active_o    = active_reg;
  assign triggered_flag_out_o  = triggered_flag_out_reg;
  assign mon_route_o = mon_reg;

  no_untrig_rd_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R08
    issue_rd |-> triggered_reg) else $error("read issued while untriggered");
  sw_triggered_flag_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R09
    ce_i && trigger_set_register_i && state_reg != ST_STOP |=> triggered_o)
    else $error("software trigger lost");
  imm_start_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R11
    ce_i && state_reg == ST_STOP && cfg_valid_i && transfer_config_i.immediate_start_bit
    |=> triggered_o && state_reg == ST_FETCH) else $error("immediate start ignored");
  paced_rd_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R12
    issue_rd && chan_cfg_i.request_pacing_enable |-> req_pend_reg ##1 !req_pend_reg || $past(periph_req_i))
    else $error("paced read without request");
  clr_triggered_flag_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R13
    ce_i && state_reg == ST_END && cfg_reg.clear_trigger_on_exhaust && !set_ev |=> !triggered_o)
    else $error("trigger not cleared on exhaustion");
  reload_go_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R17
    ce_i && state_reg == ST_END && cfg_reg.reload |=> state_reg == ST_FETCH && fbase_reg == $past(link_reg))
    else $error("reload did not follow link");
  stop_end_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R21
    ce_i && state_reg == ST_END && !cfg_reg.reload |=> state_reg == ST_STOP && !bus_o.req)
    else $error("channel not stopped on exhaustion");
  chain_out_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R07
    ce_i && state_reg == ST_END |=> triggered_flag_out_o) else $error("no trigger output");
  mon_mst_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R02
    ce_i && mon_dma_en_i && !mst_dma_en_i |=> mon_route_o == MON_MASTER)
    else $error("monitor not on master channel");
  mon_slv_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R03
    ce_i && mon_dma_en_i && mst_dma_en_i && !slv_dma_en_i |=> mon_route_o == MON_SLAVE)
    else $error("monitor not on slave channel");
  mon_none_a: assert property (@(posedge clk_i) disable iff (!arst_n_i) // see R04
    ce_i && mst_dma_en_i && slv_dma_en_i |=> mon_route_o == MON_NONE)
    else $error("monitor given dma with both on");
endmodule
`default_nettype wire

/* test/dtd_mem_model.sv */
// Purpose: memory behind the channel's bus master port
// Assumes: one request outstanding, addresses below 0x400
// Notes:   slow_i adds two wait states before each ack
`timescale 1ns/1ps
`default_nettype none
module dtd_mem_model
  import dtd_pkg::*;
(
  input  wire dtd_pkg::dtd_bus_req_s bus_i,   // request from channel
  input  wire logic                  clk_i,   // system clock
  input  wire logic                  slow_i,  // 1 answers slowly
  output logic                       ack_o,   // op done pulse
  output logic [31:0]                rdata_o  // read data with ack
);
  logic [31:0] mem [256];
  logic [1:0]  wait_reg = 2'h0;
  // rdata flips outside ack so a stale word can never pass for a fresh one
  always @(posedge clk_i) begin
    ack_o   <= 1'b0;
    rdata_o <= ~rdata_o;
    if (bus_i.req && !ack_o) begin
      wait_reg <= wait_reg + 2'h1;
      if (wait_reg >= {slow_i, 1'b0}) begin
        ack_o    <= 1'b1;
        wait_reg <= 2'h0;
        if (bus_i.we) mem[bus_i.addr[9:2]] <= bus_i.wdata;
        else rdata_o <= mem[bus_i.addr[9:2]];
      end
    end
  end
endmodule
`default_nettype wire

/* test/tb.sv */
// Purpose: self-checking bench for one dma channel
// Assumes: memory model answers every request
// Notes:   source words hold 0x1000 plus word index
`timescale 1ns/1ps
`default_nettype none
module tb;
  import dtd_pkg::*;
  logic          clk_i, arst_n_i, cfg_v, sw_t, preq, slow, ack, trg, act, tout;
  logic [3:0]    chain;
  logic [4:0]    tsel;
  logic [2:0]    mon;
  logic [31:0]   base, rdata;
  dtd_chan_cfg_s ccfg;
  dtd_xfer_cfg_s xcfg;
  dtd_bus_req_s  bus;
  dtd_mon_e      route;
  int            error_cnt, total_checks, pulses;
  dtd_channel dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(1'b1), .chan_cfg_i(ccfg),
    .transfer_config_i(xcfg), .cfg_valid_i(cfg_v), .desc_base_i(base),
    .trigger_set_register_i(sw_t), .trigger_input_select_i(tsel), .adc_seq_i(2'h0),
    .state_timer_req_i(2'h0), .timer_match_i(8'h0), .pin_int_i(4'h0),
    .chain_triggered_flag_i(chain), .periph_req_i(preq), .mst_dma_en_i(mon[2]), .slv_dma_en_i(mon[1]),
    .mon_dma_en_i(mon[0]), .bus_o(bus), .bus_ack_i(ack), .bus_rdata_i(rdata),
    .triggered_o(trg), .active_o(act), .triggered_flag_out_o(tout), .mon_route_o(route));
  dtd_mem_model m_u (.bus_i(bus), .clk_i(clk_i), .slow_i(slow), .ack_o(ack), .rdata_o(rdata));
  initial begin
    clk_i = 0;
    forever #50 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (tout === 1'b1) pulses++;
  task automatic complete_run();
    if (error_cnt == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  function automatic dtd_xfer_cfg_s xc(input logic [9:0] n, input logic [1:0] inc,
                                       input logic [2:0] f);
    xc = '0;
    xc.transfer_count = n;
    xc.source_increment = inc;
    xc.destination_increment = inc;
    xc[2:0] = f;
  endfunction
  task automatic desc(input logic [31:0] a, w0, w1, w2, w3);
    m_u.mem[a[9:2]] = w0;
    m_u.mem[a[9:2]+1] = w1;
    m_u.mem[a[9:2]+2] = w2;
    m_u.mem[a[9:2]+3] = w3;
  endtask
  // start a stopped channel, then wait a fixed pre cycles
  task automatic run(input logic [31:0] b, input dtd_xfer_cfg_s x, input int pre);
    base = b;
    xcfg = x;
    cfg_v = 1;
    tick(1);
    cfg_v = 0;
    tick(pre);
  endtask
  task automatic wait_stop();
    for (int i = 0; i < 400 && act === 1'b1; i++) tick(1);
    tick(3);
    check(act, 0);
    if (act !== 1'b0) complete_run();
  endtask
  initial begin
    arst_n_i = 0; cfg_v = 0; sw_t = 0; preq = 0; slow = 0; chain = 0; mon = 0;
    ccfg = '0; xcfg = '0; base = '0; error_cnt = 0; total_checks = 0; pulses = 0;
    tsel = 5'h10;
    for (int i = 0; i < 256; i++) m_u.mem[i] = 32'h1000 + i;
    tick(5);
    arst_n_i = 1;
    // all eight enable combinations of the two-wire functions
    for (int i = 0; i < 8; i++) begin
      mon = i[2:0];
      tick(2);
      check(route, (!i[0]) ? 0 : (!i[2]) ? 1 : (!i[1]) ? 2 : 0);
    end
    // software trigger, four words, clear trigger on exhaustion
    desc(32'h100, 32'h0, 32'h20c, 32'h30c, 32'h0);
    run(32'h100, xc(10'h3, 2'h1, 3'b001), 30);
    check(m_u.mem[8'hc0], 32'h10c0);
    sw_t = 1;
    tick(1);
    sw_t = 0;
    check(trg, 1);
    wait_stop();
    for (int k = 0; k < 4; k++) check(m_u.mem[8'hc0+k], 32'h1080 + k);
    check(trg, 0);
    check(pulses, 1);
    sw_t = 1;
    tick(1);
    sw_t = 0;
    tick(10);
    check(trg, 0);
    // immediate start with reload into a 16-byte aligned second descriptor, slow memory
    slow = 1;
    desc(32'h140, 32'h0, 32'h204, 32'h344, 32'h180);
    desc(32'h180, xc(10'h0, 2'h0, 3'b101), 32'h20c, 32'h37c, 32'h0);
    run(32'h140, xc(10'h1, 2'h1, 3'b111), 0);
    check(trg, 1);
    wait_stop();
    check(m_u.mem[8'hd0], 32'h1080);
    check(m_u.mem[8'hd1], 32'h1081);
    check(m_u.mem[8'hdf], 32'h1083);
    check(pulses, 3);
    // hardware edge trigger from chain source 16, burst, paced by requests
    slow = 0;
    ccfg = 5'b11011;
    desc(32'h1c0, 32'h0, 32'h208, 32'h3c4, 32'h0);
    run(32'h1c0, xc(10'h1, 2'h2, 3'b001), 15);
    // an edge on an unselected source must not trigger the channel
    tsel = 5'h11;
    chain = 4'h1;
    tick(1);
    chain = 4'h0;
    tick(2);
    check(trg, 0);
    tsel = 5'h10;
    chain = 4'h1;
    tick(1);
    chain = 4'h0;
    tick(15);
    check(m_u.mem[8'hef], 32'h10ef);
    repeat (2) begin
      preq = 1;
      tick(1);
      preq = 0;
      tick(15);
    end
    wait_stop();
    check(m_u.mem[8'hef], 32'h1080);
    check(m_u.mem[8'hf1], 32'h1082);
    complete_run();
  end
endmodule
`default_nettype wire
